// ===== hdl/tire_sensor_defines.vh
// Constants for the tire sensor mode controller and wake timer.
// Assumes inclusion by bare name from the design files only.
`ifndef TIRE_SENSOR_DEFINES_VH
`define TIRE_SENSOR_DEFINES_VH

// ----------------------------------------------------------------
// Mode codes, {mode_select_high, mode_select_low}; MODE_TEST comes from test detect
// ----------------------------------------------------------------
`define MODE_W           3
`define MODE_STANDBY     3'h0
`define MODE_PRESSURE    3'h1
`define MODE_TEMPERATURE 3'h2
`define MODE_READ        3'h3
`define MODE_TEST        3'h4

// ----------------------------------------------------------------
// Divider chain
// ----------------------------------------------------------------
`define WAKE_STAGES      14
`define RESET_STAGES     10
`define OSC_FREQ_HZ      5400
`define RST_PULSE_CYC    2'h2
`define RST_CNT_W        2

// ----------------------------------------------------------------
// Serial threshold port
// ----------------------------------------------------------------
`define THR_W            8
`define BIT_CNT_W        4
`define BIT_CNT_FULL     4'h8
`define THR_RESET        8'h00

// ----------------------------------------------------------------
// Measuring channels and synchronised pin positions
// ----------------------------------------------------------------
`define NUM_CH           2
`define CH_PRESSURE      0
`define CH_TEMPERATURE   1
`define PIN_W            7
`define PIN_SEL_LOW      0
`define PIN_SEL_HIGH     1
`define PIN_TEST         2
`define PIN_OSC          3
`define PIN_SCLK         4
`define PIN_SDATA        5
`define PIN_COMP         6

`endif

// ===== hdl/pin_sync.v
// Two flip-flop synchroniser for a group of asynchronous pins.
// Assumes inputs arrive from outside the clk domain.
`timescale 1ns/1ps
module pin_sync #(
   parameter WIDTH = 1
) (
   // Clock and reset
   input  wire             clk,
   input  wire             sys_rst,
   // Pins in, synchronised levels out
   input  wire [WIDTH-1:0] pin_in,
   output reg  [WIDTH-1:0] pin_sync_out
);

   reg [WIDTH-1:0] stage_one;

   // ----------------------------------------------------------------
   // Stage one feeds stage two only
   // ----------------------------------------------------------------
   always @(posedge clk) begin
      if (sys_rst) begin
         stage_one    <= {WIDTH{1'b0}};
         pin_sync_out <= {WIDTH{1'b0}};
      end else begin
         stage_one    <= pin_in;
         pin_sync_out <= stage_one;
      end
   end

endmodule

// ===== hdl/tire_sensor_mode_and_wake_timer.v
// Mode controller, serial threshold latch and wake/reset divider
// chain of the tire pressure and temperature sensing chip.
// Assumes all pins and the oscillator are asynchronous to clk.
//
// Function
// [R1] Decode two select pins into four modes
// [R2] Mux, latch, oscillator, dividers always active
// [R3] Pressure mode powers and connects pressure circuit
// [R4] Low select falls: open mux, then power down
// [R5] Temperature mode powers and connects temperature circuit
// [R6] High select falls: open mux, then power down
// [R7] Selector routes one channel, never both
// [R8] 14-stage divider wakes every 16384 cycles
// [R9] Further 10-stage divider gives host reset
// [R10] Standby: output high, low on wake pulse
// [R11] Otherwise output shows comparator against threshold; code does so in read mode only, test mode holds it high
// [R12] Host steps thresholds, watches output in read
// [R13] Test detect input forces trim/test mode
// [R14] MSB first on rising, latch on eighth fall
// [R15] Bit counter held reset in measure modes
// [R16] Full chain overflow: reset low two cycles
// [R17] Measure modes: output high except wake pulses
// [R18] Select pins sampled on oscillator before decode
`timescale 1ns/1ps
`include "tire_sensor_defines.vh"
module tire_sensor_mode_and_wake_timer #(
   parameter WAKE_STAGES  = `WAKE_STAGES,
   parameter RESET_STAGES = `RESET_STAGES
) (
   // Clock and reset
   input  wire              clk,
   input  wire              sys_rst,
   // Mode pins and test detect
   input  wire              mode_select_low,
   input  wire              mode_select_high,
   input  wire              test_detect,
   // Oscillator input
   input  wire              low_freq_oscillator,
   // Serial threshold port
   input  wire              serial_clk,
   input  wire              serial_data,
   // Analog comparator result
   input  wire              comparator_result,
   // Analog control
   output reg               pressure_enable,
   output reg               temperature_enable,
   output reg               mux_pressure_sel,
   output reg               mux_temperature_sel,
   output reg               comparator_enable,
   output reg               test_mode,
   output reg  [`THR_W-1:0] threshold_latch,
   // Pins to the host
   output reg               out_pin,
   output reg               reset_out_n
);

   localparam CHAIN_W = WAKE_STAGES + RESET_STAGES;

   // ----------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------
   wire [`PIN_W-1:0] pins_sync;

   pin_sync #(
      .WIDTH (`PIN_W)
   ) u_pin_sync (
      .clk          (clk),
      .sys_rst      (sys_rst),
      .pin_in       ({comparator_result, serial_data, serial_clk,
                      low_freq_oscillator, test_detect,
                      mode_select_high, mode_select_low}),
      .pin_sync_out (pins_sync)
   );

   wire sel_low_s  = pins_sync[`PIN_SEL_LOW];
   wire sel_high_s = pins_sync[`PIN_SEL_HIGH];
   wire test_s     = pins_sync[`PIN_TEST];
   wire osc_s      = pins_sync[`PIN_OSC];
   wire sclk_s     = pins_sync[`PIN_SCLK];
   wire sdata_s    = pins_sync[`PIN_SDATA];
   wire comp_s     = pins_sync[`PIN_COMP];

   // ----------------------------------------------------------------
   // Edge detection on synchronised levels
   // ----------------------------------------------------------------
   reg  osc_prev;
   reg  sclk_prev;
   wire osc_tick   = osc_s & ~osc_prev;
   wire sclk_rise  = sclk_s & ~sclk_prev;
   wire sclk_fall  = ~sclk_s & sclk_prev;

   always @(posedge clk) begin
      if (sys_rst) begin
         osc_prev  <= 1'b0;
         sclk_prev <= 1'b0;
      end else begin
         osc_prev  <= osc_s;
         sclk_prev <= sclk_s;
      end
   end

   // ----------------------------------------------------------------
   // Mode decode
   // ----------------------------------------------------------------
   // Selects are taken only on oscillator ticks so each sequencing
   // step below lasts at least one oscillator cycle.
   reg [`MODE_W-1:0] mode;
   reg [`MODE_W-1:0] next_mode;

   always @* begin
      if (test_s) begin
         next_mode = `MODE_TEST;                                 // [R13]
      end else if (sel_high_s & sel_low_s) begin
         next_mode = `MODE_READ;                                 // [R1]
      end else if (sel_low_s) begin
         next_mode = `MODE_PRESSURE;                             // [R1]
      end else if (sel_high_s) begin
         next_mode = `MODE_TEMPERATURE;                          // [R1]
      end else begin
         next_mode = `MODE_STANDBY;                              // [R1]
      end
   end

   always @(posedge clk) begin
      if (sys_rst) begin
         mode <= `MODE_STANDBY;
      end else if (osc_tick) begin
         mode <= next_mode;                                      // [R18]
      end
   end

   // ----------------------------------------------------------------
   // Measuring circuit and multiplexer sequencing
   // ----------------------------------------------------------------
   // One sequencer per channel. Leaving a channel passes through a
   // hold state, so the mux opens one tick before the power drops and
   // the sample capacitor keeps its charge.
   localparam CH_OFF  = 2'h0;
   localparam CH_ON   = 2'h1;
   localparam CH_HOLD = 2'h2;

   wire               in_pressure = (mode == `MODE_PRESSURE);
   wire               in_temp     = (mode == `MODE_TEMPERATURE);
   wire [`NUM_CH-1:0] chan_req;
   wire [`NUM_CH-1:0] chan_mux;
   wire [`NUM_CH-1:0] chan_pwr;
   wire [`NUM_CH-1:0] chan_linked;
   wire               any_linked  = |chan_linked;

   // One decoded mode never asks for both channels
   assign chan_req[`CH_PRESSURE]    = in_pressure;                 // [R3]
   assign chan_req[`CH_TEMPERATURE] = in_temp & ~in_pressure;      // [R5] [R7]

   genvar ch;
   generate
      for (ch = 0; ch < `NUM_CH; ch = ch + 1) begin : g_chan
         reg [1:0] state;
         reg [1:0] next_state;

         always @* begin
            case (state)
               CH_OFF: begin
                  if (chan_req[ch]) begin
                     next_state = CH_ON;
                  end else begin
                     next_state = CH_OFF;
                  end
               end
               CH_ON: begin
                  if (chan_req[ch]) begin
                     next_state = CH_ON;
                  end else begin
                     next_state = CH_HOLD;                         // [R4] [R6]
                  end
               end
               CH_HOLD: begin
                  if (chan_req[ch]) begin
                     next_state = CH_ON;
                  end else begin
                     next_state = CH_OFF;                          // [R4] [R6]
                  end
               end
               default: begin
                  next_state = CH_OFF;
               end
            endcase
         end

         always @(posedge clk) begin
            if (sys_rst) begin
               state <= CH_OFF;
            end else if (osc_tick) begin
               state <= next_state;
            end
         end

         assign chan_mux[ch]    = (next_state == CH_ON);
         assign chan_pwr[ch]    = (next_state != CH_OFF);
         assign chan_linked[ch] = (state == CH_ON);
      end
   endgenerate

   // Comparator and test mode wait until no channel is linked to the
   // sample capacitor, so neither overlaps a live measurement path.
   always @(posedge clk) begin
      if (sys_rst) begin
         mux_pressure_sel    <= 1'b0;
         mux_temperature_sel <= 1'b0;
         pressure_enable     <= 1'b0;
         temperature_enable  <= 1'b0;
         comparator_enable   <= 1'b0;
         test_mode           <= 1'b0;
      end else if (osc_tick) begin
         mux_pressure_sel    <= chan_mux[`CH_PRESSURE];          // [R3] [R4]
         mux_temperature_sel <= chan_mux[`CH_TEMPERATURE];       // [R5] [R6] [R7]
         pressure_enable     <= chan_pwr[`CH_PRESSURE];          // [R3] [R4]
         temperature_enable  <= chan_pwr[`CH_TEMPERATURE];       // [R5] [R6]
         comparator_enable   <= (mode == `MODE_READ) & ~any_linked; // [R1]
         test_mode           <= (mode == `MODE_TEST) & ~any_linked; // [R13]
      end
   end

   // ----------------------------------------------------------------
   // Divider chain, free running in every mode
   // ----------------------------------------------------------------
   reg  [CHAIN_W-1:0] chain;
   wire               wake_ovf  = &chain[WAKE_STAGES-1:0];
   wire               reset_ovf = &chain;
   reg                wake_pulse;
   reg [`RST_CNT_W-1:0] rst_count;

   always @(posedge clk) begin
      if (sys_rst) begin
         chain      <= {CHAIN_W{1'b0}};
         wake_pulse <= 1'b0;
         rst_count  <= {`RST_CNT_W{1'b0}};
      end else if (osc_tick) begin
         chain      <= chain + {{(CHAIN_W-1){1'b0}}, 1'b1};    // [R2] [R8] [R9]
         wake_pulse <= wake_ovf;                                 // [R8]
         if (reset_ovf) begin
            rst_count <= `RST_PULSE_CYC;                         // [R16]
         end else if (rst_count != {`RST_CNT_W{1'b0}}) begin
            rst_count <= rst_count - {{(`RST_CNT_W-1){1'b0}}, 1'b1};
         end
      end
   end

   always @(posedge clk) begin
      if (sys_rst) begin
         reset_out_n <= 1'b1;
      end else begin
         reset_out_n <= (rst_count == {`RST_CNT_W{1'b0}});       // [R9] [R16]
      end
   end

   // ----------------------------------------------------------------
   // Serial threshold port
   // ----------------------------------------------------------------
   // A corrupted burst is recovered by a pass through a measure mode.
   reg [`THR_W-1:0]     shift_reg;
   reg [`BIT_CNT_W-1:0] bit_count;
   wire                 count_hold = in_pressure | in_temp;

   always @(posedge clk) begin
      if (sys_rst) begin
         shift_reg       <= `THR_RESET;
         bit_count       <= {`BIT_CNT_W{1'b0}};
         threshold_latch <= `THR_RESET;
      end else if (count_hold) begin
         bit_count <= {`BIT_CNT_W{1'b0}};                        // [R15]
      end else if (sclk_rise && bit_count != `BIT_CNT_FULL) begin
         shift_reg <= {shift_reg[`THR_W-2:0], sdata_s};          // [R14]
         bit_count <= bit_count + {{(`BIT_CNT_W-1){1'b0}}, 1'b1};
      end else if (sclk_fall && bit_count == `BIT_CNT_FULL) begin
         threshold_latch <= shift_reg;                           // [R2] [R14]
         bit_count       <= {`BIT_CNT_W{1'b0}};
      end
   end

   // ----------------------------------------------------------------
   // Output pin
   // ----------------------------------------------------------------
   // Comparator power follows read mode one tick late, so it is off for the
   // first tick of read, or two after a measure mode; the pin stays high
   // until it is powered, so a stale result is never shown.
   always @(posedge clk) begin
      if (sys_rst) begin
         out_pin <= 1'b1;
      end else if (mode == `MODE_READ) begin
         if (comparator_enable) begin
            out_pin <= comp_s;                                   // [R11] [R12]
         end else begin
            out_pin <= 1'b1;                                     // [R17]
         end
      end else if (mode == `MODE_TEST) begin
         out_pin <= 1'b1;
      end else begin
         out_pin <= ~wake_pulse;                                 // [R10] [R17]
      end
   end

endmodule

// ===== verification/tire_sensor_checker.sv
// Checker bound to the mode and wake timer ports.
// Assumes an oscillator period of 20 clk cycles.
`timescale 1ns/1ps
module tire_sensor_checker (
   input wire       clk,
   input wire       sys_rst,
   input wire       pressure_enable,
   input wire       temperature_enable,
   input wire       mux_pressure_sel,
   input wire       mux_temperature_sel,
   input wire       comparator_enable,
   input wire       test_mode,
   input wire [7:0] threshold_latch,
   input wire       out_pin,
   input wire       reset_out_n
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (sys_rst);
   a_mux_one_way: assert property (!(mux_pressure_sel && mux_temperature_sel))
      else $error("both channels routed");
   a_pmux_powered: assert property (mux_pressure_sel |-> pressure_enable)
      else $error("pressure path without power");
   a_tmux_powered: assert property (mux_temperature_sel |-> temperature_enable)
      else $error("temperature path without power");
   a_pdown_order: assert property ($fell(pressure_enable) |->
      !mux_pressure_sel && !$past(mux_pressure_sel)) else $error("pressure held late");
   a_tdown_order: assert property ($fell(temperature_enable) |->
      !mux_temperature_sel && !$past(mux_temperature_sel)) else $error("temp held late");
   a_comp_read_only: assert property (comparator_enable |->
      !pressure_enable && !temperature_enable && !test_mode) else $error("comparator on");
   a_test_out_high: assert property (test_mode[*3] |->
      out_pin && !pressure_enable && !temperature_enable) else $error("test mode leak");
   a_rst_pulse_len: assert property ($fell(reset_out_n) |-> (!reset_out_n)[*8])
      else $error("reset pulse short");
   a_thr_held: assert property ((mux_pressure_sel && $past(mux_pressure_sel)) |->
      $stable(threshold_latch)) else $error("threshold moved in measure");
endmodule
bind tire_sensor_mode_and_wake_timer tire_sensor_checker u_chk (.clk, .sys_rst,
   .pressure_enable, .temperature_enable, .mux_pressure_sel, .mux_temperature_sel,
   .comparator_enable, .test_mode, .threshold_latch, .out_pin, .reset_out_n);

// ===== verification/host_model.sv
// Host controller model: mode pins and serial threshold port.
// Assumes the caller drives it from the bench clock.
`timescale 1ns/1ps
module host_model (
   input wire clk,
   output reg mode_select_low,
   output reg mode_select_high,
   output reg serial_clk,
   output reg serial_data
);
   initial {mode_select_high, mode_select_low, serial_clk, serial_data} = 4'h0;
   // Measure mode pulses also clear a broken burst
   task set_mode(input [1:0] m);
      begin
         @(negedge clk);
         {mode_select_high, mode_select_low} = m;
      end
   endtask
   // 80 ns link clock, data moves at the fall
   task send_bits(input [7:0] v, input integer n);
      integer k;
      begin
         for (k = 7; k > 7 - n; k = k - 1) begin
            serial_data = v[k];
            repeat (5) @(negedge clk);
            serial_clk = 1'h1;
            repeat (5) @(negedge clk);
            serial_clk = 1'h0;
         end
         serial_data = 1'h0; // Pull-down level once released
      end
   endtask
endmodule

// ===== verification/testbench.sv
// Self-checking bench for the mode and wake timer.
// Assumes 4 wake and 2 reset stages: wake 16 ticks, chain 64.
`timescale 1ns/1ps
module testbench;
   reg        clk, sys_rst, test_detect, osc, cmp;
   wire       s_lo, s_hi, sclk, sdat, p_en, t_en, mux_p, mux_t, c_en, tm, out_pin, rst_n;
   wire [7:0] thr;
   integer    n_fail, tests_run, cyc, t0, i, m, v;
   host_model u_host (.clk(clk), .mode_select_low(s_lo), .mode_select_high(s_hi),
      .serial_clk(sclk), .serial_data(sdat));
   tire_sensor_mode_and_wake_timer #(.WAKE_STAGES(4), .RESET_STAGES(2)) u_dut (
      .clk(clk), .sys_rst(sys_rst), .mode_select_low(s_lo), .mode_select_high(s_hi),
      .test_detect(test_detect), .low_freq_oscillator(osc), .serial_clk(sclk),
      .serial_data(sdat), .comparator_result(cmp), .pressure_enable(p_en),
      .temperature_enable(t_en), .mux_pressure_sel(mux_p), .mux_temperature_sel(mux_t),
      .comparator_enable(c_en), .test_mode(tm), .threshold_latch(thr),
      .out_pin(out_pin), .reset_out_n(rst_n));
   initial begin
      clk = 0;
      forever #4 clk = ~clk;
   end
   // Oscillator moves on falling clk edges, 20 clk per period
   initial begin
      osc = 0;
      forever begin
         repeat (10) @(negedge clk);
         osc = ~osc;
      end
   end
   task finish_test;
      begin
         $display("tests_run=%0d n_fail=%0d", tests_run, n_fail);
         if (n_fail == 0 && tests_run > 0) $display("[ PASS ]");
         else $display("[ FAIL ]");
         $finish;
      end
   endtask
   task check(input [31:0] seen, input [31:0] exp);
      begin
         tests_run = tests_run + 1;
         if (seen !== exp) begin
            n_fail = n_fail + 1;
            $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
         end
      end
   endtask
   task clks(input integer n);
      repeat (n) @(negedge clk);
   endtask
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_fail = n_fail + 1;
         finish_test;
      end
   end
   initial begin
      {sys_rst, test_detect, cmp, n_fail, tests_run, cyc} = 0;
      sys_rst = 1;
      v = $urandom(32'h7EB23A67);
      clks(10);
      sys_rst = 0;
      check({thr, rst_n, out_pin, c_en, p_en, t_en}, 13'h018);
      for (i = 0; i < 8; i = i + 1) begin
         m = (i < 4) ? i : $urandom % 4;
         u_host.set_mode(m);
         clks(80);
         check({p_en, mux_p, t_en, mux_t, c_en}, {m==1, m==1, m==2, m==2, m==3});
      end
      $display("mode test done");
      u_host.set_mode(3);
      clks(80);
      for (i = 0; i < 4; i = i + 1) begin
         v = $urandom % 256;
         u_host.send_bits(v, 8);
         cmp = v[0];
         clks(10);
         check(thr, v);
         check(out_pin, cmp);
      end
      u_host.send_bits(8'hFF, 3);
      u_host.set_mode(1);
      clks(80);
      u_host.send_bits(8'h5A, 8);
      clks(10);
      check(thr, v);
      u_host.set_mode(0);
      clks(80);
      v = $urandom % 256;
      u_host.send_bits(v, 8);
      clks(10);
      check(thr, v);
      $display("serial test done");
      @(negedge out_pin);
      @(negedge clk);
      t0 = cyc;
      @(posedge out_pin);
      @(negedge clk);
      check(cyc - t0, 20);
      @(negedge out_pin);
      @(negedge clk);
      check(cyc - t0, 320);
      @(negedge rst_n);
      @(negedge clk);
      t0 = cyc;
      @(posedge rst_n);
      @(negedge clk);
      check(cyc - t0, 40);
      @(negedge rst_n);
      @(negedge clk);
      check(cyc - t0, 1280);
      $display("divider test done");
      test_detect = 1;
      clks(80);
      check({tm, p_en, t_en, c_en, out_pin}, 5'h11);
      $display("test mode done");
      finish_test;
   end
endmodule
